/* ddc_tuning_config_regs.sv */
// tuning configuration register bank with input source multiplexer
`timescale 1ns/1ps
`default_nettype none
module ddc_tuning_config_regs
  import ddc_tuning_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  input  wire logic                sys_clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  input  wire logic [SW-1:0]       sample_port_first_i,
  input  wire logic [SW-1:0]       sample_port_second_i,
  input  wire logic [SW-1:0]       test_sample_i,
  output logic      [15:0]         chan_a_oscillator_phase_angle_o,
  output logic      [31:0]         chan_b_freq_word_o,
  output logic      [15:0]         chan_b_oscillator_phase_angle_o,
  output logic      [SW-1:0]       chan_a_sample_o,
  output logic      [SW-1:0]       chan_b_sample_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0]       chan_a_phase_stage;
    logic [31:0]       chan_b_freq_stage;
    logic [15:0]       chan_b_phase_stage;
    logic [15:0]       chan_a_phase_live;
    logic [31:0]       chan_b_freq_live;
    logic [15:0]       chan_b_phase_live;
    logic [1:0]        src_a;
    logic [1:0]        src_b;
    logic [DATA_W-1:0] rdata;
    logic [SW-1:0]     samp_a;
    logic [SW-1:0]     samp_b;
  } state_type;

  // which register a bus index names
  typedef enum {
    SEL_NONE,
    SEL_A_PHASE_LO,
    SEL_A_PHASE_HI,
    SEL_B_FREQ,
    SEL_B_PHASE_LO,
    SEL_B_PHASE_HI,
    SEL_SOURCE,
    SEL_COMMIT
  } reg_sel_type;

  state_type state_reg;
  state_type state_next;

  // ****************************************************************
  // decoding
  // ****************************************************************
  // shared by write and read paths so both always agree on the map
  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
    if (a == CHAN_A_PHASE_LO_ADDR) begin
      decode = SEL_A_PHASE_LO;
    end else if (a == CHAN_A_PHASE_HI_ADDR) begin
      decode = SEL_A_PHASE_HI;
    end else if (a >= CHAN_B_FREQ_B0_ADDR && a <= CHAN_B_FREQ_B3_ADDR) begin
      decode = SEL_B_FREQ;
    end else if (a == CHAN_B_PHASE_LO_ADDR) begin
      decode = SEL_B_PHASE_LO;
    end else if (a == CHAN_B_PHASE_HI_ADDR) begin
      decode = SEL_B_PHASE_HI;
    end else if (a == SOURCE_ADDR) begin
      decode = SEL_SOURCE;
    end else if (a == COMMIT_ADDR) begin
      decode = SEL_COMMIT;
    end else begin
      // unmapped: writes dropped, reads give zero
      decode = SEL_NONE;
    end
  endfunction

  // one byte lane of a wider word
  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
    byte_of = w[8*lane +: 8];
  endfunction

  function automatic logic [SW-1:0] pick_source(input logic [1:0] sel,
                                                input logic [SW-1:0] first,
                                                input logic [SW-1:0] second,
                                                input logic [SW-1:0] test);
    if (sel == SRC_FIRST) begin
      pick_source = first;
    end else if (sel == SRC_SECOND) begin
      pick_source = second;
    end else begin
      pick_source = test;
    end
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    reg_sel_type sel;
    logic [1:0]  lane;
    sel        = decode(addr_i);
    lane       = 2'(addr_i - CHAN_B_FREQ_B0_ADDR);
    state_next = state_reg;

    // write path
    if (wr_i) begin
      case (sel)
        SEL_A_PHASE_LO: begin
          state_next.chan_a_phase_stage[7:0] = wdata_i;
        end
        SEL_A_PHASE_HI: begin
          state_next.chan_a_phase_stage[15:8] = wdata_i;
        end
        SEL_B_FREQ: begin
          state_next.chan_b_freq_stage[8*lane +: 8] = wdata_i;
        end
        SEL_B_PHASE_LO: begin
          state_next.chan_b_phase_stage[7:0] = wdata_i;
        end
        SEL_B_PHASE_HI: begin
          state_next.chan_b_phase_stage[15:8] = wdata_i;
        end
        SEL_SOURCE: begin
          state_next.src_a = wdata_i[SRC_A_LSB +: 2];
          state_next.src_b = wdata_i[SRC_B_LSB +: 2];
        end
        SEL_COMMIT: begin
          // whole-word transfer to oscillator; staged bytes never leak
          // costs one extra write per update, but no torn frequency steps
          state_next.chan_a_phase_live = state_reg.chan_a_phase_stage;
          state_next.chan_b_freq_live  = state_reg.chan_b_freq_stage;
          state_next.chan_b_phase_live = state_reg.chan_b_phase_stage;
        end
        default: begin
          state_next.src_a = state_reg.src_a;
        end
      endcase
    end

    // read path: staged bytes read back, so software sees what it wrote
    state_next.rdata = '0;
    if (rd_i) begin
      case (sel)
        SEL_A_PHASE_LO: begin
          state_next.rdata = state_reg.chan_a_phase_stage[7:0];
        end
        SEL_A_PHASE_HI: begin
          state_next.rdata = state_reg.chan_a_phase_stage[15:8];
        end
        SEL_B_FREQ: begin
          state_next.rdata = byte_of(state_reg.chan_b_freq_stage, lane);
        end
        SEL_B_PHASE_LO: begin
          state_next.rdata = state_reg.chan_b_phase_stage[7:0];
        end
        SEL_B_PHASE_HI: begin
          state_next.rdata = state_reg.chan_b_phase_stage[15:8];
        end
        SEL_SOURCE: begin
          state_next.rdata = {4'h0, state_reg.src_b, state_reg.src_a};
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end

    state_next.samp_a = pick_source(state_reg.src_a, sample_port_first_i,
                                    sample_port_second_i, test_sample_i);
    state_next.samp_b = pick_source(state_reg.src_b, sample_port_first_i,
                                    sample_port_second_i, test_sample_i);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg               <= '0;
      state_reg.chan_a_phase_stage <= PHASE_RESET;
      state_reg.chan_b_freq_stage  <= FREQ_RESET;
      state_reg.chan_b_phase_stage <= PHASE_RESET;
      // live words clear too, so the oscillator starts at a known point
      state_reg.chan_a_phase_live  <= PHASE_RESET;
      state_reg.chan_b_freq_live   <= FREQ_RESET;
      state_reg.chan_b_phase_live  <= PHASE_RESET;
      state_reg.src_a         <= SRC_A_RESET;
      state_reg.src_b         <= SRC_B_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // angle = 2*pi*word/65536, word passed raw to oscillator
  assign chan_a_oscillator_phase_angle_o = state_reg.chan_a_phase_live;
  assign chan_b_oscillator_phase_angle_o = state_reg.chan_b_phase_live;
  assign chan_b_freq_word_o = state_reg.chan_b_freq_live;
  assign chan_a_sample_o    = state_reg.samp_a;
  assign chan_b_sample_o    = state_reg.samp_b;
  assign rdata_o            = state_reg.rdata;

endmodule
`default_nettype wire

/* ddc_tuning_config_regs_test.sv */
// self-checking bench for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module ddc_tuning_config_regs_test
  import ddc_tuning_pkg::*;
;
  // ****************
  // bench
  // ****************
  logic sys_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  logic [SAMPLE_W-1:0] s1 = 14'h0123, s2 = 14'h0abc, st = 14'h1f0f, sa, sb;
  logic [15:0] pa, pb;
  logic [31:0] fb;
  logic [7:0] v [11:18] = '{8'hef, 8'hbe, 8'h01, 8'h00, 8'h00, 8'h80, 8'h34, 8'h12};
  int fail_count = 0, n_compared = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  ddc_tuning_config_regs dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_port_first_i(s1),
    .sample_port_second_i(s2), .test_sample_i(st), .chan_a_oscillator_phase_angle_o(pa),
    .chan_b_freq_word_o(fb), .chan_b_oscillator_phase_angle_o(pb), .chan_a_sample_o(sa),
    .chan_b_sample_o(sb));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // strobes stay up until the next call, so calls run back to back
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    #1 chk({24'h0, rdata_o}, {24'h0, e});
  endtask
  task automatic t_reset;
    for (int a = 11; a <= 18; a++) rd(5'(a), 8'h00);
    rd(SOURCE_ADDR, 8'h04);
    chk({pa, pb}, 32'h0);
    chk(fb, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_words;
    for (int a = 18; a >= 11; a--) bus(1'b1, 1'b0, 5'(a), v[a]);
    rd(CHAN_A_PHASE_LO_ADDR, 8'hef);
    chk(fb, 32'h0);
    bus(1'b1, 1'b0, CHAN_B_FREQ_B3_ADDR, 8'h80);
    bus(1'b1, 1'b0, COMMIT_ADDR, 8'h00);
    bus(1'b1, 1'b0, 5'h00, 8'hff);
    #1 chk(fb, 32'h8000_0001);
    chk({pa, pb}, 32'hbeef_1234);
    rd(5'h00, 8'h00);
    rd(CHAN_B_FREQ_B0_ADDR, 8'h01);
    $display("word test done");
  endtask
  task automatic t_source;
    logic [SAMPLE_W-1:0] pick [4];
    pick = '{s1, s2, st, st};
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 1'b0, SOURCE_ADDR, 8'(i));
      bus(1'b0, 1'b0, 5'h00, 8'h00);
      @(posedge sys_clk_i);
      #1 chk({2'b00, sa, 2'b00, sb}, {2'b00, pick[i%4], 2'b00, pick[i/4]});
    end
    rd(SOURCE_ADDR, 8'h0f);
    $display("source test done");
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset;
    t_words;
    t_source;
    wrap_up;
  end
  // tests take about 90 cycles; this leaves ample margin
  initial begin
    #20000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire

/* ddc_tuning_pkg.sv */
// shared constants for the tuning configuration register bank
package ddc_tuning_pkg;
  localparam int          ADDR_W            = 5;
  localparam int          DATA_W            = 8;
  localparam int          SAMPLE_W          = 14;
  // register indices, byte wide
  localparam logic [4:0]  CHAN_A_PHASE_LO_ADDR = 5'h0b;
  localparam logic [4:0]  CHAN_A_PHASE_HI_ADDR = 5'h0c;
  localparam logic [4:0]  CHAN_B_FREQ_B0_ADDR  = 5'h0d;
  localparam logic [4:0]  CHAN_B_FREQ_B3_ADDR  = 5'h10;
  localparam logic [4:0]  CHAN_B_PHASE_LO_ADDR = 5'h11;
  localparam logic [4:0]  CHAN_B_PHASE_HI_ADDR = 5'h12;
  localparam logic [4:0]  SOURCE_ADDR       = 5'h13;
  localparam logic [4:0]  COMMIT_ADDR       = 5'h1f;
  // source field positions
  localparam int          SRC_A_LSB         = 0;
  localparam int          SRC_B_LSB         = 2;
  // reset values
  localparam logic [15:0] PHASE_RESET       = 16'h0000;
  localparam logic [31:0] FREQ_RESET        = 32'h0000_0000;
  localparam logic [1:0]  SRC_A_RESET       = 2'h0;
  localparam logic [1:0]  SRC_B_RESET       = 2'h1;
  localparam logic [7:0]  TEST_RESET        = 8'h00;
  // source selections
  localparam logic [1:0]  SRC_FIRST         = 2'h0;
  localparam logic [1:0]  SRC_SECOND        = 2'h1;
endpackage

/* ddc_tuning_props.sv */
// assertion checker for the tuning register bank
`timescale 1ns/1ps
`default_nettype none
module ddc_tuning_props
  import ddc_tuning_pkg::*;
#(parameter int SW = SAMPLE_W) (
  input wire logic              sys_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [4:0]        addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [7:0]        rdata_o,
  input wire logic [SW-1:0]     sample_port_first_i,
  input wire logic [SW-1:0]     test_sample_i,
  input wire logic [15:0]       chan_a_oscillator_phase_angle_o,
  input wire logic [31:0]       chan_b_freq_word_o,
  input wire logic [SW-1:0]     chan_a_sample_o
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire cmt = wr_i && addr_i == COMMIT_ADDR;
  rd_window_a: assert property (rdata_o != 8'h00 |-> $past(rd_i)) else $error("stray data");
  unmapped_rd_a: assert property (rd_i && addr_i == 5'h00 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  freq_hold_a: assert property (!cmt |=> $stable(chan_b_freq_word_o)) else $error("freq moved");
  phase_hold_a: assert property (chan_a_oscillator_phase_angle_o !=
    $past(chan_a_oscillator_phase_angle_o) |-> $past(cmt)) else $error("phase moved");
  phase_rdbk_a: assert property (wr_i && addr_i == CHAN_A_PHASE_LO_ADDR ##1 rd_i &&
    addr_i == CHAN_A_PHASE_LO_ADDR |=> rdata_o == $past(wdata_i, 2)) else $error("phase readback");
  freq_msb_a: assert property (wr_i && addr_i == CHAN_B_FREQ_B3_ADDR ##1 cmt |=>
    chan_b_freq_word_o[31:24] == $past(wdata_i, 2)) else $error("freq top byte");
  test_src_a: assert property (wr_i && addr_i == SOURCE_ADDR && wdata_i[1] |=>
    ##1 chan_a_sample_o == $past(test_sample_i)) else $error("test source");
  first_src_a: assert property (wr_i && addr_i == SOURCE_ADDR && wdata_i[1:0] == 2'h0
    |=> ##1 chan_a_sample_o == $past(sample_port_first_i)) else $error("first source");
  cover property (cmt);
  cover property (rd_i && addr_i == SOURCE_ADDR);
  cover property (wr_i && addr_i == SOURCE_ADDR && wdata_i[1]);
endmodule
bind ddc_tuning_config_regs ddc_tuning_props #(.SW(SW)) props_u (.*);
`default_nettype wire
